/* verilog/slbc_top.sv */
`timescale 1ns/10ps
module slbc_top
    import slbc_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    // Sync and fault inputs
    input  wire logic        HSYNC_IN,
    input  wire logic        VSYNC_IN,
    input  wire logic        FLYBACK_PULSE_IN,
    input  wire logic        OVERVOLTAGE_PROTECT_IN,
    input  wire logic        SUPPLY_LOW_IN,
    input  wire logic        VSCAN_START_IN,
    // Outputs
    output logic             HOSC_TICK,
    output logic             VOSC_TRIGGER,
    output logic             CLAMP_PULSE,
    output logic             VBLANK_PULSE,
    output logic             CONT_BLANK,
    output logic             PHASE_CORR_EN,
    output logic             BUF_FREQ_TV_CLAMP,
    output logic      [15:0] BUF_FREQ_VALUE,
    output logic             UNLOCK_STATUS_OUT,
    output logic             UNLOCK_STATUS_OE
);

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    slbc_ctrl_s   ctrl_ff;
    logic [7:0]   miss_limit_ff;
    logic [1:0]   hs_hist_ff, vs_hist_ff;
    logic         hpol_ff, vpol_ff;
    logic [15:0]  hpol_acc_ff, vpol_acc_ff;
    logic [15:0]  line_cnt_ff, meas_per_ff;
    logic [15:0]  osc_per_ff, osc_cnt_ff;
    logic [7:0]   miss_cnt_ff;
    logic         sync_lost_ff;
    logic [9:0]   vint_cnt_ff;
    logic [5:0]   clamp_cnt_ff;
    logic [5:0]   vertical_blank_length_select_lines_ff;
    logic         vertical_blank_length_select_ff;
    logic         vtrig_prev_ff;
    logic [5:0]   soft_lines_ff;
    logic         vsync_seen_ff;
    logic         fly_seen_ff, fly_missing_ff;
    slbc_loop_e   loop_ff, nxt_loop;

    // Normalized sync: pulse is the minority level of the raw input.
    logic hs_n, vs_n, hs_rise, hs_fall;
    assign hs_n    = hs_hist_ff[0] ^ hpol_ff;
    assign vs_n    = vs_hist_ff[0] ^ vpol_ff;
    assign hs_rise = (hs_hist_ff[0] ^ hpol_ff) & ~(hs_hist_ff[1] ^ hpol_ff);
    assign hs_fall = ~(hs_hist_ff[0] ^ hpol_ff) & (hs_hist_ff[1] ^ hpol_ff);

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_ff       <= slbc_ctrl_s'(CTRL_RESET[4:0]);
            miss_limit_ff <= MISS_LIMIT_RESET;
        end else begin
            if (REG_WR && REG_ADDR == ADDR_CTRL) begin
                ctrl_ff <= slbc_ctrl_s'({REG_WDATA[CTRL_CLAMP_TRAIL], REG_WDATA[CTRL_VERTICAL_BLANK_LENGTH_SELECT_LONG],
                                         REG_WDATA[CTRL_BLK_DIS], REG_WDATA[CTRL_TV_MODE],
                                         REG_WDATA[CTRL_SOFT_REL]});
            end else if (OVERVOLTAGE_PROTECT_IN) begin
                // Protection trip forces soft start; software must set it again.
                ctrl_ff.soft_rel <= 1'b0;
            end
            if (REG_WR && REG_ADDR == ADDR_MISS) begin
                miss_limit_ff <= REG_WDATA[7:0];
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                ADDR_CTRL:   REG_RDATA <= {11'h000, ctrl_ff.soft_rel, ctrl_ff.tv_mode,
                                           ctrl_ff.blk_dis, ctrl_ff.vertical_blank_length_select_long,
                                           ctrl_ff.clamp_trail};
                ADDR_STATUS: REG_RDATA <= {10'h000, fly_missing_ff, sync_lost_ff, hpol_ff,
                                           vpol_ff, loop_ff};
                ADDR_PERIOD: REG_RDATA <= meas_per_ff;
                ADDR_MISS:   REG_RDATA <= {8'h00, miss_limit_ff};
                default:     REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Polarity detection by integration
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            // Idle-high inputs, the usual case, then show no false edge at release.
            hs_hist_ff  <= 2'b11;
            vs_hist_ff  <= 2'b11;
            hpol_acc_ff <= 16'h8000;
            vpol_acc_ff <= 16'h8000;
            hpol_ff     <= 1'b1;
            vpol_ff     <= 1'b1;
        end else begin
            hs_hist_ff <= {hs_hist_ff[0], HSYNC_IN};
            vs_hist_ff <= {vs_hist_ff[0], VSYNC_IN};
            // Up/down integrators saturate; the majority level is the idle level.
            if (HSYNC_IN && hpol_acc_ff != 16'hFFFF) hpol_acc_ff <= hpol_acc_ff + 16'h0001;
            else if (!HSYNC_IN && hpol_acc_ff != 16'h0000) hpol_acc_ff <= hpol_acc_ff - 16'h0001;
            if (VSYNC_IN && vpol_acc_ff != 16'hFFFF) vpol_acc_ff <= vpol_acc_ff + 16'h0001;
            else if (!VSYNC_IN && vpol_acc_ff != 16'h0000) vpol_acc_ff <= vpol_acc_ff - 16'h0001;
            hpol_ff <= hpol_acc_ff[15];
            vpol_ff <= vpol_acc_ff[15];
        end
    end

    // ------------------------------------------------------------------
    // Vertical sync extraction
    // ------------------------------------------------------------------
    logic vint_hit, vtrig;
    assign vint_hit = (vint_cnt_ff >= 10'(VINT_CYC));
    assign vtrig    = vint_hit | vs_n;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            vint_cnt_ff   <= 10'h000;
            vtrig_prev_ff <= 1'b0;
            VOSC_TRIGGER  <= 1'b0;
        end else begin
            // Only a broad pulse survives the integrator; the gaps between line pulses reset it.
            if (!hs_n) vint_cnt_ff <= 10'h000;
            else if (!vint_hit) vint_cnt_ff <= vint_cnt_ff + 10'h001;
            vtrig_prev_ff <= vtrig;
            VOSC_TRIGGER  <= vtrig & ~vtrig_prev_ff;
        end
    end

    // ------------------------------------------------------------------
    // Clamp one-shot and vertical blanking
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            clamp_cnt_ff <= 6'h00;
            CLAMP_PULSE  <= 1'b0;
        end else begin
            if (ctrl_ff.clamp_trail ? hs_fall : hs_rise)
                clamp_cnt_ff <= 6'(CLAMP_CYC);
            else if (clamp_cnt_ff != 6'h00)
                clamp_cnt_ff <= clamp_cnt_ff - 6'h01;
            CLAMP_PULSE <= (clamp_cnt_ff != 6'h00);
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            vertical_blank_length_select_ff       <= 1'b0;
            vertical_blank_length_select_lines_ff <= 6'h00;
        end else if (vtrig & ~vtrig_prev_ff) begin
            vertical_blank_length_select_ff       <= 1'b1;
            vertical_blank_length_select_lines_ff <= ctrl_ff.vertical_blank_length_select_long ? 6'(VERTICAL_BLANK_LENGTH_SELECT_LONG_LINES)
                                               : 6'(VERTICAL_BLANK_LENGTH_SELECT_SHORT_LINES);
        end else if (vertical_blank_length_select_ff && HOSC_TICK) begin
            // Scan starts after the selected line count or on the scan marker.
            if (vertical_blank_length_select_lines_ff == 6'h01 || VSCAN_START_IN) vertical_blank_length_select_ff <= 1'b0;
            vertical_blank_length_select_lines_ff <= vertical_blank_length_select_lines_ff - 6'h01;
        end else if (VSCAN_START_IN) begin
            vertical_blank_length_select_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Line period measurement and oscillator
    // ------------------------------------------------------------------
    logic [20:0] dev_scaled;
    logic [15:0] per_diff, tv_lo, tv_hi;
    logic        deviates, coincide;
    assign per_diff = (meas_per_ff > osc_per_ff) ? meas_per_ff - osc_per_ff
                                                 : osc_per_ff - meas_per_ff;
    // A multiply keeps the 4% limit exact without a divider in the loop path.
    assign dev_scaled = 21'(per_diff) * DEV_DIV;
    assign deviates   = (dev_scaled > {5'h00, osc_per_ff}) | sync_lost_ff;
    assign coincide   = ~deviates;
    assign tv_lo      = PER_TV - TV_SPAN;
    assign tv_hi      = PER_TV + TV_SPAN;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            line_cnt_ff  <= 16'h0000;
            meas_per_ff  <= PER_MAX;
            miss_cnt_ff  <= 8'h00;
            sync_lost_ff <= 1'b1;
        end else if (hs_rise) begin
            line_cnt_ff  <= 16'h0001;
            meas_per_ff  <= line_cnt_ff;
            miss_cnt_ff  <= 8'h00;
            sync_lost_ff <= 1'b0;
        end else begin
            if (line_cnt_ff != 16'hFFFF) line_cnt_ff <= line_cnt_ff + 16'h0001;
            if (HOSC_TICK && line_cnt_ff > osc_per_ff) begin
                if (miss_cnt_ff >= miss_limit_ff) sync_lost_ff <= 1'b1;
                else miss_cnt_ff <= miss_cnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_per_ff <= PER_MAX;
            osc_cnt_ff <= 16'h0000;
            HOSC_TICK  <= 1'b0;
        end else begin
            HOSC_TICK  <= (osc_cnt_ff >= osc_per_ff - 16'h0001);
            osc_cnt_ff <= (osc_cnt_ff >= osc_per_ff - 16'h0001) ? 16'h0000
                                                                : osc_cnt_ff + 16'h0001;
            if (sync_lost_ff || !ctrl_ff.soft_rel) begin
                osc_per_ff <= PER_MAX;
            end else if (ctrl_ff.tv_mode) begin
                // TV: phase loop may only pull within its narrow span.      
                if (meas_per_ff < tv_lo) osc_per_ff <= tv_lo;
                else if (meas_per_ff > tv_hi) osc_per_ff <= tv_hi;
                else if (HOSC_TICK) osc_per_ff <= meas_per_ff;
            end else if (loop_ff == LOOP_SEARCH && HOSC_TICK) begin
                if (osc_per_ff < meas_per_ff && osc_per_ff < PER_MAX)
                    osc_per_ff <= osc_per_ff + SEARCH_STEP;
                else if (osc_per_ff > meas_per_ff && osc_per_ff > PER_MIN)
                    osc_per_ff <= osc_per_ff - SEARCH_STEP;
            end else if (loop_ff != LOOP_SEARCH && HOSC_TICK) begin
                osc_per_ff <= meas_per_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // Lock sequencing
    // ------------------------------------------------------------------
    always_comb begin
        nxt_loop = loop_ff;
        case (loop_ff)
            LOOP_HOLD:   nxt_loop = ctrl_ff.soft_rel ? LOOP_SEARCH : LOOP_HOLD;
            LOOP_SEARCH: nxt_loop = coincide ? LOOP_SOFT : LOOP_SEARCH;
            LOOP_SOFT:   nxt_loop = deviates ? LOOP_SEARCH
                                  : (vsync_seen_ff && soft_lines_ff == 6'h00) ? LOOP_NORMAL
                                  : LOOP_SOFT;
            LOOP_NORMAL: nxt_loop = deviates ? LOOP_SEARCH : LOOP_NORMAL;
            default:     nxt_loop = LOOP_HOLD;
        endcase
        if (!ctrl_ff.soft_rel) nxt_loop = LOOP_HOLD;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            loop_ff       <= LOOP_HOLD;
            vsync_seen_ff <= 1'b0;
            soft_lines_ff <= 6'h00;
            PHASE_CORR_EN <= 1'b0;
        end else begin
            loop_ff <= nxt_loop;
            if (nxt_loop != LOOP_SOFT) begin
                vsync_seen_ff <= 1'b0;
                soft_lines_ff <= 6'(SOFTLOCK_LINES);
            end else if (vtrig & ~vtrig_prev_ff) begin
                vsync_seen_ff <= 1'b1;
            end else if (vsync_seen_ff && HOSC_TICK && soft_lines_ff != 6'h00) begin
                soft_lines_ff <= soft_lines_ff - 6'h01;
            end
            // Dropped in the same cycle search is entered.
            PHASE_CORR_EN <= (nxt_loop == LOOP_NORMAL);
        end
    end

    // ------------------------------------------------------------------
    // Blanking, status pin and frequency buffer
    // ------------------------------------------------------------------
    logic protect, unlock_blank;
    assign protect      = ~ctrl_ff.soft_rel | fly_missing_ff | OVERVOLTAGE_PROTECT_IN
                        | SUPPLY_LOW_IN;
    assign unlock_blank = (loop_ff == LOOP_SEARCH) | sync_lost_ff;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            fly_seen_ff    <= 1'b0;
            fly_missing_ff <= 1'b0;
        end else if (HOSC_TICK) begin
            fly_missing_ff <= ~fly_seen_ff & ctrl_ff.soft_rel;
            fly_seen_ff    <= FLYBACK_PULSE_IN;
        end else if (FLYBACK_PULSE_IN) begin
            fly_seen_ff <= 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CONT_BLANK        <= 1'b1;
            VBLANK_PULSE      <= 1'b0;
            UNLOCK_STATUS_OUT <= 1'b0;
            UNLOCK_STATUS_OE  <= 1'b0;
            BUF_FREQ_TV_CLAMP <= 1'b0;
            BUF_FREQ_VALUE    <= 16'h0000;
        end else begin
            CONT_BLANK   <= protect | (unlock_blank & ~ctrl_ff.blk_dis);
            VBLANK_PULSE <= vertical_blank_length_select_ff;
            // Floating lets the pull-up signal search-without-sync or fault.
            UNLOCK_STATUS_OE  <= ~(protect
                                  | ((loop_ff == LOOP_SEARCH) & sync_lost_ff));
            UNLOCK_STATUS_OUT <= vertical_blank_length_select_ff | (unlock_blank & ~ctrl_ff.blk_dis);
            BUF_FREQ_TV_CLAMP <= ctrl_ff.tv_mode;
            BUF_FREQ_VALUE    <= ctrl_ff.tv_mode ? PER_TV : osc_per_ff;
        end
    end

endmodule : slbc_top

/* verilog/slbc_pkg.sv */
package slbc_pkg;

    // ------------------------------------------------------------------
    // Register map (word addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_PERIOD = 4'h2;
    localparam logic [3:0] ADDR_MISS   = 4'h3;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_CLAMP_TRAIL = 0;
    localparam int CTRL_VERTICAL_BLANK_LENGTH_SELECT_LONG   = 1;
    localparam int CTRL_BLK_DIS     = 2;
    localparam int CTRL_TV_MODE     = 3;
    localparam int CTRL_SOFT_REL    = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MISS_LIMIT_RESET = 8'h04;

    // ------------------------------------------------------------------
    // Timing, in ns and derived 25 MHz cycles
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 40;
    localparam int CLAMP_NS        = 600;
    localparam int CLAMP_CYC       = (CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VINT_NS         = 8000;
    localparam int VINT_CYC        = (VINT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VERTICAL_BLANK_LENGTH_SELECT_SHORT_LINES = 16;
    localparam int VERTICAL_BLANK_LENGTH_SELECT_LONG_LINES  = 24;
    localparam int SOFTLOCK_LINES   = 32;
    // Oscillator period range in cycles: f_min about 15.6 kHz, f_max 130 kHz.
    localparam logic [15:0] PER_MAX = 16'h0640;
    localparam logic [15:0] PER_MIN = 16'h00C0;
    localparam logic [15:0] PER_TV  = 16'h0640;
    localparam logic [15:0] SEARCH_STEP = 16'h0001;
    // Deviation is flagged when 25 times the period error exceeds the period: 4%.
    localparam logic [20:0] DEV_DIV = 21'h000019;
    // The TV phase loop may pull the period by a tenth either way.
    localparam logic [15:0] TV_SPAN = PER_TV / 16'h000A;

    // ------------------------------------------------------------------
    // Loop state and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LOOP_SEARCH = 2'b00,
        LOOP_SOFT   = 2'b01,
        LOOP_NORMAL = 2'b10,
        LOOP_HOLD   = 2'b11
    } slbc_loop_e;

    typedef struct packed {
        logic       clamp_trail;
        logic       vertical_blank_length_select_long;
        logic       blk_dis;
        logic       tv_mode;
        logic       soft_rel;
    } slbc_ctrl_s;

endpackage : slbc_pkg

/* sim/slbc_props.sv */
`timescale 1ns/10ps
module slbc_props
    import slbc_pkg::*;
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // Inputs seen by the block
    input wire logic        OVERVOLTAGE_PROTECT_IN,
    input wire logic        SUPPLY_LOW_IN,
    input wire logic        VSCAN_START_IN,
    // Block outputs
    input wire logic        VOSC_TRIGGER,
    input wire logic        CLAMP_PULSE,
    input wire logic        VBLANK_PULSE,
    input wire logic        CONT_BLANK,
    input wire logic        PHASE_CORR_EN,
    input wire logic        BUF_FREQ_TV_CLAMP,
    input wire logic [15:0] BUF_FREQ_VALUE,
    input wire logic        UNLOCK_STATUS_OUT,
    input wire logic        UNLOCK_STATUS_OE
);
    // A retriggered or stretched clamp shows up as a wrong count here.
    logic [7:0] clamp_len_ff;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            clamp_len_ff <= 8'h00;
        end else begin
            clamp_len_ff <= CLAMP_PULSE ? clamp_len_ff + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    clamp_width_a: assert property (
        $fell(CLAMP_PULSE) |-> clamp_len_ff == 8'(CLAMP_CYC))
        else $error("clamp pulse width wrong");
    vtrig_pulse_a: assert property (VOSC_TRIGGER |=> !VOSC_TRIGGER)
        else $error("vertical trigger longer than one cycle");
    prot_blank_a: assert property (OVERVOLTAGE_PROTECT_IN |-> ##[1:4] CONT_BLANK)
        else $error("no blanking on protection trip");
    supply_blank_a: assert property (SUPPLY_LOW_IN |-> ##[1:4] CONT_BLANK)
        else $error("no blanking on low supply");
    prot_float_a: assert property (
        OVERVOLTAGE_PROTECT_IN |-> ##[1:4] !UNLOCK_STATUS_OE)
        else $error("status pin driven during protection");
    prot_loop_off_a: assert property (
        OVERVOLTAGE_PROTECT_IN |-> ##[1:4] !PHASE_CORR_EN)
        else $error("loop still correcting during protection");
    tv_hold_a: assert property (BUF_FREQ_TV_CLAMP |-> BUF_FREQ_VALUE == PER_TV)
        else $error("buffer value not held in tv mode");
    scan_end_a: assert property (VSCAN_START_IN |-> ##[1:2] !VBLANK_PULSE)
        else $error("vertical blank not ended at scan start");
    vblank_start_a: assert property (VOSC_TRIGGER |=> VBLANK_PULSE)
        else $error("vertical blank not started by vertical trigger");
    status_vblank_a: assert property (VBLANK_PULSE |-> UNLOCK_STATUS_OUT)
        else $error("vertical blank missing on status pin");
endmodule : slbc_props

bind slbc_top slbc_props u_props (
    .MCLK, .RST_N, .OVERVOLTAGE_PROTECT_IN, .SUPPLY_LOW_IN, .VSCAN_START_IN,
    .VOSC_TRIGGER, .CLAMP_PULSE, .VBLANK_PULSE, .CONT_BLANK, .PHASE_CORR_EN,
    .BUF_FREQ_TV_CLAMP, .BUF_FREQ_VALUE, .UNLOCK_STATUS_OUT, .UNLOCK_STATUS_OE
);

/* sim/slbc_sync_src.sv */
`timescale 1ns/10ps
module slbc_sync_src
    import slbc_pkg::*;
(
    // Clock and control
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [15:0] period,
    input  wire logic        hosc_tick,
    // Lines into the block
    output logic             hsync_n,
    output logic             vsync_n,
    output logic             vscan_start,
    output logic             flyback
);
    logic [15:0] pix_ff;
    logic [7:0]  line_ff;
    logic [7:0]  fly_ff;
    logic        eol;
    assign eol = (pix_ff >= period - 16'h0001);
    // Plain separated sync, 20 lines a frame, no equalization pulses.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_ff  <= 16'h0000;
            line_ff <= 8'h00;
        end else if (!run) begin
            pix_ff  <= 16'h0000;
            line_ff <= 8'h00;
        end else begin
            pix_ff <= eol ? 16'h0000 : pix_ff + 16'h0001;
            if (eol) begin
                line_ff <= (line_ff >= 8'h13) ? 8'h00 : line_ff + 8'h01;
            end
        end
    end
    assign hsync_n     = !run || (pix_ff >= 16'h0060);
    assign vsync_n     = !run || (line_ff >= 8'h03);
    assign vscan_start = run && (line_ff == 8'h06) && (pix_ff == 16'h0000);
    // The deflection stage answers the block's own line tick, with or without sync.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fly_ff <= 8'h00;
        end else begin
            fly_ff <= hosc_tick ? 8'h40 : fly_ff - {7'h00, fly_ff != 8'h00};
        end
    end
    assign flyback = (fly_ff != 8'h00);
endmodule : slbc_sync_src

/* sim/slbc_tb_top.sv */
`timescale 1ns/10ps
module slbc_tb_top
    import slbc_pkg::*;
;
    localparam logic [15:0] SOFT = 16'(1 << CTRL_SOFT_REL);
    localparam logic [15:0] TVB  = 16'(1 << CTRL_TV_MODE);
    logic        mclk, rst_n, reg_wr, reg_rd, run, ov_trip, supply_low;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, rdata, buf_val, period, rd;
    logic        hsync, vsync, flyback, vscan, tick, clamp, cont_blank;
    logic        corr_en, tv_clamp, unlock_oe;
    int          fails, check_count;

    slbc_top dut (.MCLK(mclk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .HSYNC_IN(hsync),
        .VSYNC_IN(vsync), .FLYBACK_PULSE_IN(flyback), .OVERVOLTAGE_PROTECT_IN(ov_trip),
        .SUPPLY_LOW_IN(supply_low), .VSCAN_START_IN(vscan), .HOSC_TICK(tick),
        .VOSC_TRIGGER(), .CLAMP_PULSE(clamp), .VBLANK_PULSE(), .CONT_BLANK(cont_blank),
        .PHASE_CORR_EN(corr_en), .BUF_FREQ_TV_CLAMP(tv_clamp), .BUF_FREQ_VALUE(buf_val),
        .UNLOCK_STATUS_OUT(), .UNLOCK_STATUS_OE(unlock_oe));
    slbc_sync_src u_src (.clk(mclk), .rst_n(rst_n), .run(run), .period(period),
        .hosc_tick(tick), .hsync_n(hsync), .vsync_n(vsync), .vscan_start(vscan),
        .flyback(flyback));

    // ------------------------------------------------------------------
    // Register access, compares and verdict
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : reg_write
    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : reg_read
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : cycles
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check_word(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : check_word
    task automatic check_bit(input string what, input logic e, input logic g);
        check_word(what, {15'h0000, e}, {15'h0000, g});
    endtask : check_bit
    task automatic wait_for(input string what, input bit sel_clamp, input logic v, input int lim);
        int n;
        n = 0;
        @(negedge mclk);
        while ((sel_clamp ? clamp : corr_en) !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
        check_bit(what, v, sel_clamp ? clamp : corr_en);
        if (fails != 0) begin
            give_verdict();
        end
    endtask : wait_for

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        fails = 0;
        check_count = 0;
        {rst_n, reg_wr, reg_rd, run, ov_trip, supply_low} = 6'h00;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        period = 16'h0604;
        repeat (2) @(posedge mclk);
        check_bit("blank in reset", 1'b1, cont_blank);
        check_bit("status pin in reset", 1'b0, unlock_oe);
        rst_n <= 1'b1;
        reg_read(ADDR_CTRL, rd);
        check_word("ctrl reset", {8'h00, CTRL_RESET}, rd);
        reg_read(ADDR_MISS, rd);
        check_word("miss limit reset", {8'h00, MISS_LIMIT_RESET}, rd);
        reg_read(4'hF, rd);
        check_word("unmapped read", 16'h0000, rd);
        reg_write(ADDR_CTRL, SOFT);
        cycles(4000);
        check_word("free run period", PER_MAX, buf_val);
        reg_read(ADDR_STATUS, rd);
        check_word("search without sync", 16'h0010 | 16'(LOOP_SEARCH), rd & 16'h0013);
        check_bit("status floats", 1'b0, unlock_oe);
        check_bit("search blank", 1'b1, cont_blank);
        @(posedge mclk);
        run <= 1'b1;
        for (int i = 0; i < 90 && rd[1:0] !== LOOP_NORMAL; i++) begin
            repeat (1000) @(posedge mclk);
            reg_read(ADDR_STATUS, rd);
        end
        check_word("loop locked", 16'(LOOP_NORMAL), rd & 16'h0003);
        check_bit("phase correction on", 1'b1, corr_en);
        reg_read(ADDR_PERIOD, rd);
        check_word("measured period", period, rd);
        for (int t = 0; t < 2; t++) begin
            reg_write(ADDR_CTRL, SOFT | 16'(t));
            wait_for("clamp idle", 1'b1, 1'b0, 100);
            wait_for("clamp start", 1'b1, 1'b1, 3200);
            check_bit("sync level at clamp", t[0], hsync);
        end
        @(posedge mclk);
        period <= 16'h04B0;
        wait_for("phase correction off", 1'b0, 1'b0, 3400);
        reg_write(ADDR_CTRL, SOFT | TVB);
        cycles(4);
        check_bit("tv clamp", 1'b1, tv_clamp);
        check_word("tv level", PER_TV, buf_val);
        reg_write(ADDR_CTRL, SOFT | 16'h0006);
        cycles(4);
        check_bit("tv clamp released", 1'b0, tv_clamp);
        check_bit("unlock blank disabled", 1'b0, cont_blank);
        reg_read(ADDR_CTRL, rd);
        check_word("ctrl readback", 16'h0016, rd);
        @(posedge mclk);
        supply_low <= 1'b1;
        cycles(4);
        check_bit("low supply blank", 1'b1, cont_blank);
        @(posedge mclk);
        supply_low <= 1'b0;
        ov_trip    <= 1'b1;
        cycles(4);
        @(posedge mclk);
        ov_trip <= 1'b0;
        cycles(2);
        check_bit("protect blank", 1'b1, cont_blank);
        check_bit("protect floats", 1'b0, unlock_oe);
        reg_read(ADDR_CTRL, rd);
        check_word("soft start forced", 16'h0006, rd);
        give_verdict();
    end
endmodule : slbc_tb_top
